// *** rtl/sfp_sideband_pkg.sv ***
package sfp_sideband_pkg;
  localparam int NUM_PORTS = 2;
  localparam int ID_W = 48;
  localparam int PORT_STRIDE = 8;
  localparam int BASE_CLK_MHZ = 40;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PORT_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_ID_BASE = 8'h20;
  localparam logic [7:0] ID_PORT_STEP = 8'h08;
  localparam logic [7:0] ID_HI_OFS = 8'h04;

  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_POL_BIT = 2;
  localparam int STATUS_HELD_BIT = 31;

  localparam int PF_TX_DIS = 0;
  localparam int PF_POWER = 1;
  localparam int PF_RATE = 2;
  localparam int RATE_W = 2;
  localparam int PF_SCL_LOW = 4;
  localparam int PF_SDA_LOW = 5;
  localparam logic [7:0] PORT_FIELD_MASK = 8'h3f;

  localparam int SF_FAULT = 0;
  localparam int SF_LOS = 1;
  localparam int SF_PRESENT = 2;
  localparam int SF_ID_VALID = 3;
  localparam int SF_POWER_OK = 4;
  localparam int SF_SCL = 5;
  localparam int SF_SDA = 6;
  localparam int SYNC_FIELDS = 7;
  localparam int EV_COUNT = 5;

  typedef enum logic [1:0] {
    APP_HELD = 2'b01,
    APP_RUNNING = 2'b10
  } app_state_e;
endpackage

// *** rtl/sync_2ff.sv ***
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage is read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// *** rtl/port_monitor.sv ***
`timescale 1ns/1ps
module port_monitor
  import sfp_sideband_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fault,
  input wire logic los,
  input wire logic present_raw,
  input wire logic id_valid,
  input wire logic power_ok,
  input wire logic [ID_W-1:0] id,
  input wire logic polarity,
  output logic present,
  output logic [EV_COUNT-1:0] events,
  output logic [ID_W-1:0] id_q,
  output logic id_ok
);
  logic fault_d, los_d, pres_d, valid_d, pok_d;

  assign present = present_raw ^ polarity;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_d <= 1'b0;
      los_d <= 1'b0;
      pres_d <= 1'b0;
      valid_d <= 1'b0;
      pok_d <= 1'b0;
      events <= '0;
    end else begin
      fault_d <= fault;
      los_d <= los;
      pres_d <= present;
      valid_d <= id_valid;
      pok_d <= power_ok;
      events[SF_FAULT] <= fault & ~fault_d;
      events[SF_LOS] <= los & ~los_d;
      events[SF_PRESENT] <= present ^ pres_d;
      events[SF_ID_VALID] <= id_valid & ~valid_d;
      events[SF_POWER_OK] <= pok_d & ~power_ok;
    end
  end

  // capture once at the rise; the bus is settled by then
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      id_q <= '0;
      id_ok <= 1'b0;
    end else begin
      id_ok <= id_valid;
      if (!id_valid) begin
        id_q <= '0;
      end else if (!valid_d) begin
        id_q <= id;
      end
    end
  end
endmodule

// *** rtl/sfp_port_sideband_control.sv ***
// What this block does
// - clk is a free-running base clock, never gated, and clocks everything.
// - app reset rises on a reset command, falls only on a later run command.
// - laser-fault input is an async level, high meaning transmitter fault.
// - signal-loss input is an async level, high meaning receive power too low.
// - presence input is async; its polarity is configurable, not assumed.
// - each port gets a unique 48-bit station id for its network controller.
// - a per-port valid flag qualifies the station id; invalid ids read zero.
// - power-good input shows supply enabled; may drop on over-power.
// - serial data pads belong to the transceiver only, not to this logic.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module sfp_port_sideband_control
  import sfp_sideband_pkg::*;
#(
  parameter int NP = sfp_sideband_pkg::NUM_PORTS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic fpga_async_reset_input,
  input wire logic [NP-1:0] port_tx_fault,
  input wire logic [NP-1:0] port_rx_signal_loss,
  input wire logic [NP-1:0] port_module_presence,
  input wire logic [NP-1:0] port_station_id_valid,
  input wire logic [NP*sfp_sideband_pkg::ID_W-1:0] port_station_id,
  input wire logic [NP-1:0] port_cable_power_ok,
  output logic [NP-1:0] port_tx_disable,
  output logic [NP*sfp_sideband_pkg::RATE_W-1:0] port_rate_select,
  output logic [NP-1:0] port_cable_power_on,
  input wire logic [NP-1:0] module_definition_line_one_in,
  output logic [NP-1:0] module_definition_line_one_out,
  output logic [NP-1:0] module_definition_line_one_oe,
  input wire logic [NP-1:0] module_definition_line_two_in,
  output logic [NP-1:0] module_definition_line_two_out,
  output logic [NP-1:0] module_definition_line_two_oe
);
  import sfp_sideband_pkg::*;

  // transceiver pads are not routed here at all

  logic [SYNC_FIELDS*NP-1:0] raw_vec;
  logic [SYNC_FIELDS*NP-1:0] s_vec;
  logic [NP*ID_W-1:0] id_s;
  logic [NP-1:0] fault_s, los_s, pres_s, valid_s, pok_s, scl_s, sda_s;
  logic [NP-1:0] present;
  logic [NP-1:0] id_ok;
  logic [EV_COUNT-1:0] ev [NP];
  logic [ID_W-1:0] id_q [NP];

  app_state_e app_state;
  logic pol_reg;
  logic [31:0] port_ctrl_reg;
  logic [31:0] irq_stat_reg;
  logic [31:0] irq_mask_reg;
  logic [31:0] status_vec;
  logic [31:0] ev_vec;
  logic [31:0] rdata;
  logic hit;
  logic apb_do;
  logic apb_rd;
  logic wr_ctrl;
  logic held;

  // all pin levels cross into clk through two flops
  assign raw_vec = {module_definition_line_two_in, module_definition_line_one_in,
                    port_cable_power_ok, port_station_id_valid,
                    port_module_presence, port_rx_signal_loss, port_tx_fault};

  sync_2ff #(.W(SYNC_FIELDS*NP)) u_sync_status (
    .clk(clk),
    .rst(rst),
    .d(raw_vec),
    .q(s_vec)
  );

  // the id bus is only trusted once its synced valid is seen
  sync_2ff #(.W(NP*ID_W)) u_sync_id (
    .clk(clk),
    .rst(rst),
    .d(port_station_id),
    .q(id_s)
  );

  assign fault_s = s_vec[SF_FAULT*NP +: NP];
  assign los_s = s_vec[SF_LOS*NP +: NP];
  assign pres_s = s_vec[SF_PRESENT*NP +: NP];
  assign valid_s = s_vec[SF_ID_VALID*NP +: NP];
  assign pok_s = s_vec[SF_POWER_OK*NP +: NP];
  assign scl_s = s_vec[SF_SCL*NP +: NP];
  assign sda_s = s_vec[SF_SDA*NP +: NP];

  for (genvar p = 0; p < NP; p++) begin : g_port
    port_monitor u_mon (
      .clk(clk),
      .rst(rst),
      .fault(fault_s[p]),
      .los(los_s[p]),
      .present_raw(pres_s[p]),
      .id_valid(valid_s[p]),
      .power_ok(pok_s[p]),
      .id(id_s[p*ID_W +: ID_W]),
      .polarity(pol_reg),
      .present(present[p]),
      .events(ev[p]),
      .id_q(id_q[p]),
      .id_ok(id_ok[p])
    );
  end

  // one wait state keeps prdata and pready registered
  assign apb_do = psel & penable & pready;
  assign apb_rd = psel & penable & ~pready;
  assign wr_ctrl = apb_do & pwrite & (paddr == ADDR_CTRL);
  assign held = (app_state == APP_HELD);

  always_comb begin
    status_vec = '0;
    ev_vec = '0;
    for (int p = 0; p < NP; p++) begin
      status_vec[p*PORT_STRIDE+SF_FAULT] = fault_s[p];
      status_vec[p*PORT_STRIDE+SF_LOS] = los_s[p];
      status_vec[p*PORT_STRIDE+SF_PRESENT] = present[p];
      status_vec[p*PORT_STRIDE+SF_ID_VALID] = id_ok[p];
      status_vec[p*PORT_STRIDE+SF_POWER_OK] = pok_s[p];
      status_vec[p*PORT_STRIDE+SF_SCL] = scl_s[p];
      status_vec[p*PORT_STRIDE+SF_SDA] = sda_s[p];
      ev_vec[p*PORT_STRIDE +: EV_COUNT] = ev[p];
    end
    status_vec[STATUS_HELD_BIT] = held;
  end

  always_comb begin
    logic [7:0] id_addr;
    id_addr = '0;
    rdata = '0;
    hit = 1'b1;
    case (paddr)
      ADDR_CTRL: rdata[CTRL_POL_BIT] = pol_reg;
      ADDR_PORT_CTRL: rdata = port_ctrl_reg;
      ADDR_STATUS: rdata = status_vec;
      ADDR_IRQ_STAT: rdata = irq_stat_reg;
      ADDR_IRQ_MASK: rdata = irq_mask_reg;
      default: begin
        hit = 1'b0;
        for (int p = 0; p < NP; p++) begin
          id_addr = ADDR_ID_BASE + ID_PORT_STEP * 8'(p);
          // an id without its valid flag reads as zero
          if (paddr == id_addr) begin
            hit = 1'b1;
            rdata = id_ok[p] ? id_q[p][31:0] : '0;
          end else if (paddr == id_addr + ID_HI_OFS) begin
            hit = 1'b1;
            rdata[ID_W-33:0] = id_ok[p] ? id_q[p][ID_W-1:32] : '0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_rd;
      if (apb_rd) begin
        prdata <= pwrite ? 32'h0 : rdata;
        pslverr <= ~hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // reset command wins over a run in the same write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      app_state <= APP_HELD;
      fpga_async_reset_input <= 1'b1;
    end else if (wr_ctrl && pwdata[CTRL_RESET_BIT]) begin
      app_state <= APP_HELD;
      fpga_async_reset_input <= 1'b1;
    end else if (wr_ctrl && pwdata[CTRL_RUN_BIT]) begin
      app_state <= APP_RUNNING;
      fpga_async_reset_input <= 1'b0;
    end else begin
      case (app_state)
        APP_HELD: fpga_async_reset_input <= 1'b1;
        APP_RUNNING: fpga_async_reset_input <= 1'b0;
        default: begin
          app_state <= APP_HELD;
          fpga_async_reset_input <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pol_reg <= 1'b0;
    end else if (wr_ctrl) begin
      pol_reg <= pwdata[CTRL_POL_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_ctrl_reg <= '0;
      for (int p = 0; p < NP; p++) begin
        port_ctrl_reg[p*PORT_STRIDE+PF_TX_DIS] <= 1'b1;
      end
    end else if (apb_do && pwrite && paddr == ADDR_PORT_CTRL) begin
      for (int p = 0; p < NP; p++) begin
        port_ctrl_reg[p*PORT_STRIDE +: PORT_STRIDE] <=
          pwdata[p*PORT_STRIDE +: PORT_STRIDE] & PORT_FIELD_MASK;
        // rate pins only change while the port's stored power bit is clear
        if (port_ctrl_reg[p*PORT_STRIDE+PF_POWER]) begin
          port_ctrl_reg[p*PORT_STRIDE+PF_RATE +: RATE_W] <=
            port_ctrl_reg[p*PORT_STRIDE+PF_RATE +: RATE_W];
        end
      end
    end
  end

  // held app forces a safe socket: laser off, power off, bus released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_tx_disable <= '1;
      port_cable_power_on <= '0;
      port_rate_select <= '0;
      module_definition_line_one_out <= '0;
      module_definition_line_two_out <= '0;
      module_definition_line_one_oe <= '0;
      module_definition_line_two_oe <= '0;
    end else begin
      module_definition_line_one_out <= '0; // only ever low
      module_definition_line_two_out <= '0;
      for (int p = 0; p < NP; p++) begin
        port_tx_disable[p] <= held | port_ctrl_reg[p*PORT_STRIDE+PF_TX_DIS];
        port_cable_power_on[p] <= ~held & port_ctrl_reg[p*PORT_STRIDE+PF_POWER];
        port_rate_select[p*RATE_W +: RATE_W] <=
          port_ctrl_reg[p*PORT_STRIDE+PF_RATE +: RATE_W];
        module_definition_line_one_oe[p] <=
          ~held & port_ctrl_reg[p*PORT_STRIDE+PF_SCL_LOW];
        module_definition_line_two_oe[p] <=
          ~held & port_ctrl_reg[p*PORT_STRIDE+PF_SDA_LOW];
      end
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else if (apb_do && pwrite && paddr == ADDR_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata) | ev_vec;
    end else begin
      irq_stat_reg <= irq_stat_reg | ev_vec;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_reg <= '0;
    end else if (apb_do && pwrite && paddr == ADDR_IRQ_MASK) begin
      irq_mask_reg <= pwdata;
    end
  end

  // clk runs free, so irq still updates with nothing plugged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  chk_reset_cmd_held: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl && pwdata[CTRL_RESET_BIT] |=> fpga_async_reset_input && held)
    else $error("reset command did not hold the app");

  chk_run_cmd_release: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl && pwdata[CTRL_RUN_BIT] && !pwdata[CTRL_RESET_BIT]
    |=> !fpga_async_reset_input ##1 !fpga_async_reset_input || wr_ctrl)
    else $error("run command did not release the app");

  chk_fault_event_sets: assert property (@(posedge clk) disable iff (rst)
    $rose(fault_s[0]) |-> ##2 irq_stat_reg[SF_FAULT])
    else $error("fault rise not latched");

  chk_loss_event_sets: assert property (@(posedge clk) disable iff (rst)
    $rose(los_s[0]) |-> ##2 irq_stat_reg[SF_LOS])
    else $error("signal loss rise not latched");

  chk_presence_polarity: assert property (@(posedge clk) disable iff (rst)
    $changed(pres_s[0]) && $stable(pol_reg) |-> ##2 irq_stat_reg[SF_PRESENT])
    else $error("presence change not latched");

  chk_power_drop_sets: assert property (@(posedge clk) disable iff (rst)
    $fell(pok_s[0]) |-> ##2 irq_stat_reg[SF_POWER_OK])
    else $error("power-good drop not latched");

  chk_id_hidden_invalid: assert property (@(posedge clk) disable iff (rst)
    apb_rd && !pwrite && paddr == ADDR_ID_BASE && !id_ok[0] |=> prdata == 32'h0)
    else $error("station id visible while invalid");

  chk_id_stable_valid: assert property (@(posedge clk) disable iff (rst)
    valid_s[0] && $past(valid_s[0]) && $past(valid_s[0], 2) |-> $stable(id_q[0]))
    else $error("station id changed while valid");

  chk_held_safe_pins: assert property (@(posedge clk) disable iff (rst)
    held |=> port_tx_disable == '1 && port_cable_power_on == '0)
    else $error("socket not safe while app held");

  chk_irq_follows_mask: assert property (@(posedge clk) disable iff (rst)
    (irq_stat_reg & irq_mask_reg) != 32'h0 |=> irq)
    else $error("unmasked event without interrupt");

  cov_app_release: cover property (@(posedge clk) disable iff (rst)
    $fell(fpga_async_reset_input));
  cov_fault_irq: cover property (@(posedge clk) disable iff (rst)
    $rose(fault_s[0]) ##2 irq_stat_reg[SF_FAULT] ##[1:20] irq);
  cov_id_capture: cover property (@(posedge clk) disable iff (rst)
    $rose(id_ok[0]));
endmodule

// *** verification/sfp_module_model.sv ***
`timescale 1ns/1ps
module sfp_module_model #(
  parameter logic [47:0] ID0 = 48'h0a1b2c3d4e5f, // arbitrary value
  parameter logic [47:0] ID1 = 48'h665544332211 // arbitrary value
) (
  input wire logic clk,
  input wire logic [1:0] plugged,
  input wire logic [1:0] fault_cmd,
  input wire logic [1:0] los_cmd,
  input wire logic [1:0] overload,
  input wire logic [1:0] power_on,
  input wire logic [1:0] scl_oe,
  input wire logic [1:0] sda_oe,
  output logic [1:0] tx_fault,
  output logic [1:0] signal_loss,
  output logic [1:0] presence,
  output logic [1:0] id_valid,
  output logic [95:0] id,
  output logic [1:0] power_ok,
  output logic [1:0] scl,
  output logic [1:0] sda
);
  assign tx_fault = fault_cmd;
  assign signal_loss = los_cmd;
  assign presence = plugged;
  assign id_valid = plugged;
  // an invalid id shows its inverse, never a stale copy
  assign id = {id_valid[1] ? ID1 : ~ID1, id_valid[0] ? ID0 : ~ID0};
  always @(posedge clk) begin
    power_ok <= power_on & ~overload;
  end
  // pull-ups: a released line reads high
  assign scl = ~scl_oe;
  assign sda = ~sda_oe;
endmodule

// *** verification/sfp_port_sideband_control_test.sv ***
`timescale 1ns/1ps
module sfp_port_sideband_control_test;
  import sfp_sideband_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, irq, app_held, err;
  logic [1:0] plugged = 2'b11;
  logic [1:0] fault_cmd = 2'b00;
  logic [1:0] los_cmd = 2'b00;
  logic [1:0] overload = 2'b00;
  logic [1:0] tx_fault, los, presence, idv, pok, tx_dis, pwr_on;
  logic [1:0] scl_oe, sda_oe, scl_out, sda_out, scl, sda;
  logic [3:0] rate;
  logic [95:0] id;
  int n_mismatch = 0;
  int num_checks = 0;

  always #10 clk = ~clk;

  sfp_port_sideband_control DUT (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .fpga_async_reset_input(app_held),
    .port_tx_fault(tx_fault), .port_rx_signal_loss(los),
    .port_module_presence(presence), .port_station_id_valid(idv),
    .port_station_id(id), .port_cable_power_ok(pok), .port_tx_disable(tx_dis),
    .port_rate_select(rate), .port_cable_power_on(pwr_on),
    .module_definition_line_one_in(scl), .module_definition_line_one_out(scl_out),
    .module_definition_line_one_oe(scl_oe), .module_definition_line_two_in(sda),
    .module_definition_line_two_out(sda_out), .module_definition_line_two_oe(sda_oe)
  );

  sfp_module_model far_end (
    .clk(clk), .plugged(plugged), .fault_cmd(fault_cmd), .los_cmd(los_cmd),
    .overload(overload), .power_on(pwr_on), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .tx_fault(tx_fault), .signal_loss(los), .presence(presence), .id_valid(idv),
    .id(id), .power_ok(pok), .scl(scl), .sda(sda)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a slave that never answers ends the run here
    if (n >= 16) begin
      chk(1'b0, 1'b1);
      test_done();
    end
  endtask

  task automatic t_reset;
    cyc(1);
    chk(app_held, 1'b1);
    chk(tx_dis, 2'b11);
    chk(pwr_on, 2'b00);
    chk({scl_oe, sda_oe}, 4'h0);
    chk(irq, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h18, 32'hffffffff);
    chk(err, 1'b1);
  endtask

  task automatic t_held_run;
    apb(1'b1, ADDR_PORT_CTRL, 32'h0202);
    cyc(3);
    chk(tx_dis, 2'b11);
    chk(pwr_on, 2'b00);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[STATUS_HELD_BIT], 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h2);
    cyc(3);
    chk(app_held, 1'b0);
    chk(tx_dis, 2'b00);
    chk(pwr_on, 2'b11);
  endtask

  task automatic t_status;
    cyc(4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h7c7c);
    fault_cmd <= 2'b01;
    los_cmd <= 2'b11;
    overload <= 2'b10;
    cyc(6);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h6e7f);
    fault_cmd <= 2'b00;
    los_cmd <= 2'b00;
    overload <= 2'b00;
    apb(1'b1, ADDR_CTRL, 32'h4);
    cyc(4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[15:0], 16'h7878);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'h0);
  endtask

  task automatic t_id;
    apb(1'b0, ADDR_ID_BASE, 32'h0);
    chk(rd, 32'h2c3d4e5f);
    apb(1'b0, ADDR_ID_BASE + ID_HI_OFS, 32'h0);
    chk(rd, 32'h0a1b);
    apb(1'b0, ADDR_ID_BASE + ID_PORT_STEP, 32'h0);
    chk(rd, 32'h44332211);
    plugged <= 2'b00;
    cyc(8);
    apb(1'b0, ADDR_ID_BASE + ID_PORT_STEP + ID_HI_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_ID_BASE, 32'h0);
    chk(rd, 32'h0);
    plugged <= 2'b11;
    cyc(8);
    apb(1'b0, ADDR_ID_BASE + ID_PORT_STEP + ID_HI_OFS, 32'h0);
    chk(rd, 32'h6655);
    apb(1'b0, ADDR_ID_BASE, 32'h0);
    chk(rd, 32'h2c3d4e5f);
  endtask

  task automatic t_irq;
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, ADDR_IRQ_STAT, 32'hffffffff);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    fault_cmd <= 2'b01;
    cyc(6);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    cyc(3);
    chk(irq, 1'b1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    cyc(3);
    chk(irq, 1'b0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    fault_cmd <= 2'b00;
  endtask

  task automatic t_lines_rate;
    apb(1'b1, ADDR_PORT_CTRL, 32'h2010);
    cyc(3);
    chk({scl_oe, sda_oe}, 4'b0110);
    chk({scl_out, sda_out}, 4'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[15:0], 16'h2c4c);
    apb(1'b1, ADDR_PORT_CTRL, 32'h0008);
    apb(1'b1, ADDR_PORT_CTRL, 32'h000a);
    apb(1'b1, ADDR_PORT_CTRL, 32'h0006);
    cyc(3);
    chk(rate, 4'h2);
    chk(pwr_on, 2'b01);
  endtask

  task automatic t_reset_cmd;
    // both commands at once: the reset one must win
    apb(1'b1, ADDR_CTRL, 32'h3);
    cyc(3);
    chk(app_held, 1'b1);
    chk(tx_dis, 2'b11);
    chk(pwr_on, 2'b00);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_held_run();
    t_status();
    t_id();
    t_irq();
    t_lines_rate();
    t_reset_cmd();
    test_done();
  end

  // whole run is well under 1000 cycles
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule
